// *** pkg/sac_pkg.sv ***
// Shared constants and types of the converter control block.
// Assumes a single 10 MHz system clock and a word-wide register port.
package sac_pkg;

  // ---------------------------------------------------------------
  // Register indexes on the register port
  // ---------------------------------------------------------------
  localparam logic [3:0] REG_CONTROL  = 4'h0;
  localparam logic [3:0] REG_POS_CHAN = 4'h1;
  localparam logic [3:0] REG_NEG_CHAN = 4'h2;
  localparam logic [3:0] REG_STATUS   = 4'h3;
  localparam logic [3:0] REG_RESULT   = 4'h4;
  localparam logic [3:0] REG_RESET    = 4'h5;
  localparam logic [3:0] REG_GAIN     = 4'h6;
  localparam logic [3:0] REG_OFFSET   = 4'h7;

  // ---------------------------------------------------------------
  // Control register field layout
  // ---------------------------------------------------------------
  localparam int CTL_W        = 12;
  localparam int CTL_ENABLE   = 0;
  localparam int CTL_MODE_LO  = 1;
  localparam int CTL_MODE_HI  = 2;
  localparam int CTL_TYPE_LO  = 3;
  localparam int CTL_TYPE_HI  = 5;
  localparam int CTL_ACQ_LO   = 6;
  localparam int CTL_ACQ_HI   = 7;
  localparam int CTL_DIV_LO   = 8;
  localparam int CTL_DIV_HI   = 10;
  localparam int CTL_BUSY_OUT = 11;
  // Eight acquisition clocks (code 2) and divider 2 (code 1) after reset
  localparam logic [CTL_W-1:0] CTL_RESET = 12'h181;

  // Input configurations
  localparam logic [1:0] MODE_SINGLE = 2'h0;
  localparam logic [1:0] MODE_DIFF   = 2'h1;
  localparam logic [1:0] MODE_PSEUDO = 2'h2;

  // Conversion type and trigger source codes
  localparam logic [2:0] TYPE_NONE   = 3'h0;
  localparam logic [2:0] TYPE_SINGLE = 3'h1;
  localparam logic [2:0] TYPE_CONT   = 3'h2;
  localparam logic [2:0] TYPE_EXT    = 3'h3;
  localparam logic [2:0] TYPE_LOGIC  = 3'h4;
  localparam logic [2:0] TYPE_FIRST_TIMER = 3'h5;
  localparam logic [2:0] TYPE_SECOND_TIMER = 3'h6;

  // Trigger input bit positions
  localparam int TRG_EXT    = 0;
  localparam int TRG_LOGIC  = 1;
  localparam int TRG_FIRST_TIMER = 2;
  localparam int TRG_SECOND_TIMER = 3;

  // ---------------------------------------------------------------
  // Result layout and timing figures
  // ---------------------------------------------------------------
  localparam int CODE_W     = 12;
  localparam int CODE_STEPS = 4096;
  localparam int RES_LO     = 16;
  localparam int RES_HI     = 27;
  localparam int SIGN_BITS  = 4;
  localparam int TRIM_W     = 10;
  localparam int GAIN_SHIFT = 12;
  localparam int EXTRA_CLKS = 19;
  localparam int TEMP_ACQ   = 16;
  localparam int TEMP_DIV   = 32;
  localparam int DEF_RATE_KSPS = 774;
  localparam int CHAN_W     = 5;
  localparam logic [CHAN_W-1:0] TEMP_CHAN = 5'h10;

  typedef enum logic [1:0] {
    SAC_IDLE,
    SAC_ACQ,
    SAC_CONV
  } sac_state_e;

  typedef struct packed {
    sac_state_e          st;
    logic [CTL_W-1:0]    ctrl;
    logic [CHAN_W-1:0]   posChan;
    logic [CHAN_W-1:0]   negChan;
    logic [TRIM_W-1:0]   gain;
    logic [TRIM_W-1:0]   offset;
    logic [31:0]         result;
    logic                ready;
    logic                tempHeld;
    logic                tempConv;
    logic                swStart;
    logic [7:0]          divCnt;
    logic [4:0]          phCnt;
    logic [3:0]          trgPrev;
    logic [31:0]         rdata;
  } sac_state_s;

endpackage

// *** logic/sac_control.sv ***
// Digital control and register file of a 12-bit successive-approximation
// converter: triggering, timing, result coding, trim and status.
// Assumes the analog core samples while acqPhase is high, makes one bit
// trial per convClkEn pulse and holds rawCode valid when the count ends.
//
// Functional notes
// - Three input configurations selected by the control register mode field.
// - Single-ended and pseudo differential results are straight binary codes.
// - Fully differential results are twos complement codes.
// - Differential result is shifted right one place before storing.
// - Twelve-bit result sits in result register bits 16 to 27.
// - Top four result bits hold copies of the sign.
// - Software starts single or continuous conversions via control register.
// - External pin, logic array, or timer overflows trigger conversions.
// - Control sets acquisition clocks and divider; reset gives eight and two.
// - Each conversion has nineteen converter clocks after acquisition.
// - Temperature channel forces sixteen acquisition clocks and divider 32.
// - Outside continuous restarts, user timing returns once the temperature result has been read.
// - Status bit 0 is result ready, set at conversion end.
// - Reading the result register clears result ready.
// - Conversion-active output is high throughout each conversion.
// - Conversion-active reaches port zero line five only when enabled.
// - Any write to the reset register restores all register defaults.
// - Gain trim register is ten bits and scales results.
// - Offset trim register is ten bits and shifts results.
// - Control holds enable, input configuration and conversion type.
// - Separate registers select positive and negative input channels.
// - Temperature sensor is one extra selectable positive channel.
// - Offset correction is digital with quarter-code steps.
`timescale 1ns/1ns

module sac_control #(
  parameter int                      EXTRA_CLOCKS   = sac_pkg::EXTRA_CLKS,
  parameter int                      TEMP_ACQ_CLKS  = sac_pkg::TEMP_ACQ,
  parameter int                      TEMP_DIVIDER   = sac_pkg::TEMP_DIV,
  parameter logic [sac_pkg::TRIM_W-1:0] GAIN_RESET  = 10'h000,
  parameter logic [sac_pkg::TRIM_W-1:0] OFFSET_RESET = 10'h000
) (
  input  wire logic                          clk,
  input  wire logic                          sys_rst,
  input  wire logic [3:0]                    regSel,
  input  wire logic                          regWrite,
  input  wire logic                          regRead,
  input  wire logic [31:0]                   regWdata,
  output logic      [31:0]                   regRdata,
  input  wire logic                          external_trigger_pin,
  input  wire logic                          logicArrayTrigger,
  input  wire logic                          firstTimerOverflow,
  input  wire logic                          secondTimerOverflow,
  input  wire logic [sac_pkg::CODE_W-1:0]    rawCode,
  output logic [sac_pkg::CHAN_W-1:0]         positive_channel_select,
  output logic [sac_pkg::CHAN_W-1:0]         negative_channel_select,
  output logic [1:0]                         inputMode,
  output logic                               converterEnable,
  output logic                               acqPhase,
  output logic                               convClkEn,
  output logic                               result_ready_flag,
  output logic                               conversion_active_pin,
  output logic                               port_zero_line_five,
  output logic                               portZeroLineFiveEn
);
  import sac_pkg::*;

  // -----------------------------------------------------------------
  // Parameter checks
  // -----------------------------------------------------------------
  // Counters are 5 and 8 bits wide; the divider must be a power of two
  if (EXTRA_CLOCKS < 1 || EXTRA_CLOCKS > 31) begin : g_chkExtra
    $error("EXTRA_CLOCKS out of range");
  end
  if (TEMP_ACQ_CLKS < 1 || TEMP_ACQ_CLKS > 31) begin : g_chkAcq
    $error("TEMP_ACQ_CLKS out of range");
  end
  if (TEMP_DIVIDER < 1 || TEMP_DIVIDER > 128 ||
      (TEMP_DIVIDER & (TEMP_DIVIDER - 1)) != 0) begin : g_chkDiv
    $error("TEMP_DIVIDER must be a power of two up to 128");
  end

  localparam logic [4:0] EXTRA_LAST = 5'(EXTRA_CLOCKS - 1);
  localparam logic [4:0] TACQ_LAST  = 5'(TEMP_ACQ_CLKS - 1);
  localparam logic [7:0] TDIV_LAST  = 8'(TEMP_DIVIDER - 1);
  localparam logic signed [15:0] DIFF_MAX  = 16'sd2047;
  localparam logic signed [15:0] DIFF_MIN  = -16'sd2048;
  localparam logic signed [15:0] UNS_MAX   = 16'(CODE_STEPS - 1);

  localparam sac_state_s RESET_VAL = '{
    st:      SAC_IDLE,
    ctrl:    CTL_RESET,
    gain:    GAIN_RESET,
    offset:  OFFSET_RESET,
    default: '0
  };

  sac_state_s state_reg;
  sac_state_s state_next;

  // -----------------------------------------------------------------
  // Decoded control fields
  // -----------------------------------------------------------------
  logic                   ctlEnable;
  logic [1:0]             ctlMode;
  logic [2:0]             ctlType;
  logic [1:0]             ctlAcq;
  logic [2:0]             ctlDiv;
  logic                   diffMode;
  logic [3:0]             trgNow;
  logic [3:0]             trgEdge;
  logic                   hwTrigger;
  logic [4:0]             acqLast;
  logic [7:0]             divLast;
  logic                   tick;
  logic                   resultRead;
  logic                   resetWrite;

  // Field slices of the live control register
  assign ctlEnable = state_reg.ctrl[CTL_ENABLE];
  assign ctlMode   = state_reg.ctrl[CTL_MODE_HI:CTL_MODE_LO];
  assign ctlType   = state_reg.ctrl[CTL_TYPE_HI:CTL_TYPE_LO];
  assign ctlAcq    = state_reg.ctrl[CTL_ACQ_HI:CTL_ACQ_LO];
  assign ctlDiv    = state_reg.ctrl[CTL_DIV_HI:CTL_DIV_LO];
  assign diffMode  = (ctlMode == MODE_DIFF);

  // -----------------------------------------------------------------
  // Hardware trigger selection
  // -----------------------------------------------------------------
  // Rising edges only, so a level held high triggers once per edge
  assign trgNow[TRG_EXT]    = external_trigger_pin;
  assign trgNow[TRG_LOGIC]  = logicArrayTrigger;
  assign trgNow[TRG_FIRST_TIMER] = firstTimerOverflow;
  assign trgNow[TRG_SECOND_TIMER] = secondTimerOverflow;
  assign trgEdge = trgNow & ~state_reg.trgPrev;

  // Only the source chosen by the conversion type can start a conversion
  always_comb begin
    case (ctlType)
      TYPE_EXT:    hwTrigger = trgEdge[TRG_EXT];
      TYPE_LOGIC:  hwTrigger = trgEdge[TRG_LOGIC];
      TYPE_FIRST_TIMER: hwTrigger = trgEdge[TRG_FIRST_TIMER];
      TYPE_SECOND_TIMER: hwTrigger = trgEdge[TRG_SECOND_TIMER];
      default:     hwTrigger = 1'b0;
    endcase
  end

  // -----------------------------------------------------------------
  // Conversion timing
  // -----------------------------------------------------------------
  // Temperature or user timing is chosen per conversion through tempConv, taken at start; user fields stay live
  always_comb begin
    if (state_reg.tempConv) begin
      acqLast = TACQ_LAST;
      divLast = TDIV_LAST;
    end else begin
      acqLast = 5'((5'h2 << ctlAcq) - 5'h1);
      divLast = 8'((8'h1 << ctlDiv) - 8'h1);
    end
  end

  // One converter clock every divLast+1 system clocks
  assign tick = (state_reg.st != SAC_IDLE) && (state_reg.divCnt == divLast);

  // Bus side effects
  assign resultRead = regRead && (regSel == REG_RESULT);
  assign resetWrite = regWrite && (regSel == REG_RESET);

  // -----------------------------------------------------------------
  // Result correction and coding
  // -----------------------------------------------------------------
  logic signed [15:0] rawSigned;
  logic signed [15:0] quarter;
  logic signed [25:0] gainProd;
  logic signed [15:0] corrected;
  logic signed [15:0] clamped;
  logic        [11:0] codeField;
  logic               signBit;
  logic        [31:0] resultWord;

  // Work in quarter-code units so the offset trim keeps its resolution
  always_comb begin
    rawSigned = '0;
    quarter   = '0;
    gainProd  = '0;
    corrected = '0;
    clamped   = '0;
    if (diffMode) begin
      rawSigned = 16'(signed'(rawCode));
    end else begin
      rawSigned = signed'({4'h0, rawCode});
    end
    quarter = 16'(rawSigned <<< 2) +
              16'(signed'(state_reg.offset));
    gainProd = 26'(quarter) * 26'(signed'(state_reg.gain));
    corrected = 16'(quarter + 16'(gainProd >>> GAIN_SHIFT));
    corrected = (corrected + 16'sd2) >>> 2;
    // Saturate rather than wrap when trim pushes past full scale
    if (diffMode) begin
      if (corrected > DIFF_MAX) begin
        clamped = DIFF_MAX;
      end else if (corrected < DIFF_MIN) begin
        clamped = DIFF_MIN;
      end else begin
        clamped = corrected;
      end
    end else begin
      if (corrected > UNS_MAX) begin
        clamped = UNS_MAX;
      end else if (corrected < 16'sd0) begin
        clamped = 16'sd0;
      end else begin
        clamped = corrected;
      end
    end
  end

  // Differential codes become a signed integer after the shift
  always_comb begin
    if (diffMode) begin
      codeField = 12'(clamped >>> 1);
      signBit   = codeField[CODE_W-1];
    end else begin
      codeField = clamped[CODE_W-1:0];
      signBit   = 1'b0;
    end
    resultWord                 = '0;
    resultWord[RES_HI:RES_LO]  = codeField;
    resultWord[31:32-SIGN_BITS] = {SIGN_BITS{signBit}};
  end

  // -----------------------------------------------------------------
  // Next-state logic
  // -----------------------------------------------------------------
  logic startReq;
  logic convDone;

  always_comb begin
    state_next = state_reg;
    startReq   = 1'b0;
    convDone   = 1'b0;
    state_next.trgPrev = trgNow;

    // Divider runs only while converting and restarts with each phase
    if (tick) begin
      state_next.divCnt = '0;
    end else if (state_reg.st != SAC_IDLE) begin
      state_next.divCnt = state_reg.divCnt + 8'h1;
    end

    // Start requests are honoured only when idle and enabled
    startReq = ctlEnable && (state_reg.swStart || hwTrigger ||
               (ctlType == TYPE_CONT));

    case (state_reg.st)
      SAC_IDLE: begin
        state_next.swStart = 1'b0;
        if (startReq) begin
          state_next.st       = SAC_ACQ;
          state_next.divCnt   = '0;
          state_next.phCnt    = '0;
          state_next.tempConv = (state_reg.posChan == TEMP_CHAN) ||
                                state_reg.tempHeld;
        end
      end
      SAC_ACQ: begin
        state_next.swStart = 1'b0;
        if (tick) begin
          if (state_reg.phCnt == acqLast) begin
            state_next.st    = SAC_CONV;
            state_next.phCnt = '0;
          end else begin
            state_next.phCnt = state_reg.phCnt + 5'h1;
          end
        end
      end
      SAC_CONV: begin
        state_next.swStart = 1'b0;
        if (tick) begin
          if (state_reg.phCnt == EXTRA_LAST) begin
            convDone          = 1'b1;
            state_next.result = resultWord;
            state_next.phCnt  = '0;
            state_next.divCnt = '0;
            if (state_reg.tempConv && state_reg.posChan == TEMP_CHAN) begin
              state_next.tempHeld = 1'b1;
            end
            if (ctlEnable && ctlType == TYPE_CONT) begin
              state_next.st       = SAC_ACQ;
              state_next.tempConv = (state_reg.posChan == TEMP_CHAN);
            end else begin
              state_next.st = SAC_IDLE;
            end
          end else begin
            state_next.phCnt = state_reg.phCnt + 5'h1;
          end
        end
      end
      default: begin
        state_next.st = SAC_IDLE;
      end
    endcase

    // Reading the result drops ready and releases the temperature timing;
    // a completion in the same cycle still wins
    if (resultRead) begin
      state_next.ready    = 1'b0;
      if (!convDone) begin
        state_next.tempHeld = 1'b0;
      end
    end
    if (convDone) begin
      state_next.ready = 1'b1;
    end

    // Register writes
    if (regWrite) begin
      case (regSel)
        REG_CONTROL: begin
          state_next.ctrl = regWdata[CTL_W-1:0];
          if (regWdata[CTL_TYPE_HI:CTL_TYPE_LO] == TYPE_SINGLE &&
              state_reg.st == SAC_IDLE) begin
            state_next.swStart = 1'b1;
          end
        end
        REG_POS_CHAN: state_next.posChan = regWdata[CHAN_W-1:0];
        REG_NEG_CHAN: state_next.negChan = regWdata[CHAN_W-1:0];
        REG_GAIN:     state_next.gain    = regWdata[TRIM_W-1:0];
        REG_OFFSET:   state_next.offset  = regWdata[TRIM_W-1:0];
        default: begin
        end
      endcase
    end

    // Read data is registered; unmapped indexes read zero
    if (regRead) begin
      case (regSel)
        REG_CONTROL:  state_next.rdata = 32'(state_reg.ctrl);
        REG_POS_CHAN: state_next.rdata = 32'(state_reg.posChan);
        REG_NEG_CHAN: state_next.rdata = 32'(state_reg.negChan);
        REG_STATUS:   state_next.rdata = 32'(state_reg.ready);
        REG_RESULT:   state_next.rdata = state_reg.result;
        REG_GAIN:     state_next.rdata = 32'(state_reg.gain);
        REG_OFFSET:   state_next.rdata = 32'(state_reg.offset);
        default:      state_next.rdata = '0;
      endcase
    end

    // Interface reset overrides everything else in this cycle
    if (resetWrite) begin
      state_next = RESET_VAL;
      state_next.trgPrev = trgNow;
    end
  end

  // -----------------------------------------------------------------
  // State register
  // -----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_reg <= RESET_VAL;
    end else begin
      state_reg <= state_next;
    end
  end

  // -----------------------------------------------------------------
  // Outputs
  // -----------------------------------------------------------------
  assign regRdata                = state_reg.rdata;
  assign positive_channel_select = state_reg.posChan;
  assign negative_channel_select = state_reg.negChan;
  assign inputMode               = ctlMode;
  assign converterEnable         = ctlEnable;
  assign acqPhase                = (state_reg.st == SAC_ACQ);
  assign convClkEn               = tick;
  assign result_ready_flag       = state_reg.ready;
  // Busy covers acquisition and bit trials alike
  assign conversion_active_pin   = (state_reg.st != SAC_IDLE);
  // Routing to the port line is gated by the control bit
  assign portZeroLineFiveEn      = state_reg.ctrl[CTL_BUSY_OUT];
  assign port_zero_line_five     = state_reg.ctrl[CTL_BUSY_OUT] &&
                                   (state_reg.st != SAC_IDLE);

endmodule

// *** testbench/sac_control_assertions.sv ***
// Checker of the converter control block: tick counts, ready flag, routing.
// Assumes a bind onto sac_control; it sees the ports only.
`timescale 1ns/1ns
module sac_control_assertions (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic [3:0]  regSel,
  input wire logic        regWrite,
  input wire logic        regRead,
  input wire logic [31:0] regRdata,
  input wire logic        converterEnable,
  input wire logic        acqPhase,
  input wire logic        convClkEn,
  input wire logic        result_ready_flag,
  input wire logic        conversion_active_pin,
  input wire logic        port_zero_line_five,
  input wire logic        portZeroLineFiveEn
);
  import sac_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ---------------------------------------------------------------
  // Tick counter
  // ---------------------------------------------------------------
  logic [4:0] convCnt;
  // Ticks since acquisition ended; a restart mid-conversion cuts it short
  always_ff @(posedge clk) begin
    if (sys_rst || acqPhase || !conversion_active_pin) convCnt <= 5'h00;
    else if (convClkEn) convCnt <= convCnt + 5'h01;
  end
  sequence convDone;
    $rose(result_ready_flag);
  endsequence
  sequence resultRead;
    regRead && regSel == REG_RESULT && !convClkEn;
  endsequence
  chk_tick_count: assert property (convDone |-> convCnt == 5'h13)
    else $error("wrong converter tick count");
  chk_no_overrun: assert property (convCnt <= 5'h13)
    else $error("conversion ran past its ticks");
  chk_no_restart: assert property ($rose(acqPhase) |-> !$past(conversion_active_pin) || convCnt == 5'h13)
    else $error("acquisition restarted mid-conversion");
  chk_ready_cause: assert property (convDone |-> $past(convClkEn) && $past(conversion_active_pin))
    else $error("ready set without a final tick");
  chk_ready_clear: assert property (resultRead |=> !result_ready_flag)
    else $error("ready survived a result read");
  chk_acq_busy: assert property (acqPhase |-> conversion_active_pin)
    else $error("acquiring while idle");
  chk_port_route: assert property (port_zero_line_five == (conversion_active_pin && portZeroLineFiveEn))
    else $error("busy routing wrong");
  chk_soft_reset: assert property (regWrite && regSel == REG_RESET && !regRead |=>
    converterEnable == CTL_RESET[CTL_ENABLE] && !result_ready_flag && !conversion_active_pin && regRdata == 32'h0)
    else $error("reset write left state behind");
endmodule

// *** testbench/sac_core_model.sv ***
// Behavioural analog core: answers bit trials with a code set by the bench.
// Assumes the control block samples rawCode only while busy.
`timescale 1ns/1ns
module sac_core_model (
  input  wire logic                       clk,
  input  wire logic                       busy,
  input  wire logic [sac_pkg::CODE_W-1:0] code,
  output logic      [sac_pkg::CODE_W-1:0] rawCode
);
  import sac_pkg::*;
  logic [CODE_W-1:0] junk = 12'h5a5;
  // Undriven outside a conversion: toggle so a stale code never passes
  always @(posedge clk) junk <= ~junk;
  assign rawCode = busy ? code : junk;
endmodule

// *** testbench/sac_control_tb_top.sv ***
// Self-checking bench of the converter control block with a core model.
// Assumes a 100 ns clock; expected words follow the result coding.
`timescale 1ns/1ns
module sac_control_tb_top;
  import sac_pkg::*;
  logic        clk = 1'b0;
  logic        sysRst = 1'b1;
  logic [3:0]  regSel = 4'h0;
  logic        regWrite = 1'b0;
  logic        regRead = 1'b0;
  logic [31:0] regWdata = 32'h0;
  logic [31:0] regRdata;
  logic [3:0]  trgIn = 4'h0;
  logic [11:0] code = 12'h0;
  logic [11:0] rawCode;
  logic        busy;
  logic [4:0]  posSel;
  logic [4:0]  negSel;
  logic [1:0]  modeOut;
  logic        rdQ = 1'b0;
  logic [11:0] c;
  logic [1:0]  m;
  logic [31:0] expQ[$];
  int          failCount = 0;
  int          nChecks = 0;
  int          cyc = 0;
  int          len;

  sac_control u_dut (.clk(clk), .sys_rst(sysRst), .regSel(regSel), .regWrite(regWrite), .regRead(regRead),
    .regWdata(regWdata), .regRdata(regRdata), .external_trigger_pin(trgIn[0]), .logicArrayTrigger(trgIn[1]),
    .firstTimerOverflow(trgIn[2]), .secondTimerOverflow(trgIn[3]), .rawCode(rawCode),
    .positive_channel_select(posSel), .negative_channel_select(negSel), .inputMode(modeOut),
    .converterEnable(), .acqPhase(), .convClkEn(), .result_ready_flag(), .conversion_active_pin(busy),
    .port_zero_line_five(),
    .portZeroLineFiveEn());
  sac_core_model u_core (.clk(clk), .busy(busy), .code(code), .rawCode(rawCode));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nChecks++;
    if (got !== exp) begin
      failCount++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic printVerdict();
    $display("checks %0d mismatches %0d", nChecks, failCount);
    if (failCount == 0 && nChecks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wr(input logic [3:0] s, input logic [31:0] d);
    @(posedge clk) #10;
    regSel = s;
    regWdata = d;
    regWrite = 1'b1;
    @(posedge clk) #10;
    regWrite = 1'b0;
  endtask
  // The read strobe notes its expected word; the watcher compares later
  task automatic rd(input logic [3:0] s, input logic [31:0] e);
    @(posedge clk) #10;
    regSel = s;
    regRead = 1'b1;
    expQ.push_back(e);
    @(posedge clk) #10;
    regRead = 1'b0;
  endtask
  task automatic defaults();
    for (int i = 0; i < 16; i++) if (i != 5) rd(i[3:0], (i == 0) ? 32'h181 : 32'h0);
  endtask
  // Start, time the busy window, retrigger midway (must be ignored), read back
  task automatic conv(input logic [31:0] ctl, input logic [11:0] cd, input int cycles, input bit rdOn,
                      input logic [31:0] e);
    code <= cd;
    wr(REG_CONTROL, ctl);
    trgIn = 4'hf;
    len = 0;
    for (int i = 0; i < 2000 && !(len > 0 && busy !== 1'b1); i++) begin
      @(posedge clk) #10;
      if (busy === 1'b1) len++;
      if (i == 3 || i == 22) trgIn = 4'h0;
      if (i == 20) trgIn = 4'hf;
    end
    chk(len, cycles);
    chk(modeOut, ctl[CTL_MODE_HI:CTL_MODE_LO]);
    if (rdOn) begin
      rd(REG_STATUS, 32'h1);
      rd(REG_RESULT, e);
      rd(REG_STATUS, 32'h0);
    end
  endtask

  always #50 clk = ~clk;
  // Watcher: a strobe seen at one edge is answered by the next
  always @(posedge clk) begin
    if (rdQ) chk(regRdata, expQ.pop_front());
    rdQ <= regRead;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failCount++;
      printVerdict();
    end
  end

  initial begin
    void'($urandom(60837));
    repeat (3) @(posedge clk);
    #10;
    sysRst = 1'b0;
    wr(REG_STATUS, 32'hffffffff);
    wr(REG_RESULT, 32'hffffffff);
    defaults();
    wr(REG_GAIN, 32'hffffffff);
    wr(REG_OFFSET, 32'h00000155);
    wr(REG_NEG_CHAN, 32'h2);
    chk(negSel, 32'h2);
    rd(REG_GAIN, 32'h3ff);
    rd(REG_OFFSET, 32'h155);
    rd(REG_NEG_CHAN, 32'h2);
    wr(REG_RESET, $urandom);
    defaults();
    // Every input configuration, the last one a negative differential code
    for (int k = 0; k < 4; k++) begin
      c = 12'($urandom);
      if (k == 3) c[11] = 1'b1;
      m = (k == 3) ? MODE_DIFF : k[1:0];
      conv(32'h189 | (m << 1) | ((k == 2) ? 32'h800 : 32'h0), c, 54, 1'b1,
           (m == MODE_DIFF) ? {{5{c[11]}}, c[11:1], 16'h0} : {4'h0, c, 16'h0});
    end
    conv(32'h0c9, c, 35, 1'b1, {4'h0, c, 16'h0});
    for (int t = 3; t < 7; t++) conv(32'h181 | (t << 3), c, 54, 1'b1, {4'h0, c, 16'h0});
    wr(REG_GAIN, 32'h100);
    conv(32'h189, 12'h640, 54, 1'b1, 32'h06a40000);
    wr(REG_GAIN, 32'h0);
    wr(REG_OFFSET, 32'h4);
    conv(32'h189, 12'h064, 54, 1'b1, 32'h00650000);
    wr(REG_OFFSET, 32'h0);
    wr(REG_POS_CHAN, 32'(TEMP_CHAN));
    chk(posSel, 32'(TEMP_CHAN));
    conv(32'h189, c, 1120, 1'b0, 32'h0);
    wr(REG_POS_CHAN, 32'h3);
    conv(32'h189, c, 1120, 1'b1, {4'h0, c, 16'h0});
    conv(32'h189, c, 54, 1'b1, {4'h0, c, 16'h0});
    // Continuous run: busy never drops across completions until stopped
    wr(REG_CONTROL, 32'h191);
    for (int i = 0; i < 10 && busy !== 1'b1; i++) @(posedge clk) #10;
    len = 0;
    repeat (130) begin
      @(posedge clk) #10;
      if (busy !== 1'b1) len++;
    end
    chk(len, 0);
    rd(REG_RESULT, {4'h0, c, 16'h0});
    wr(REG_CONTROL, 32'h180);
    for (int i = 0; i < 60 && busy !== 1'b0; i++) @(posedge clk) #10;
    chk(busy, 1'b0);
    repeat (3) @(posedge clk);
    printVerdict();
  end
endmodule

bind sac_control sac_control_assertions u_chk (.clk(clk), .sys_rst(sys_rst), .regSel(regSel),
  .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .converterEnable(converterEnable),
  .acqPhase(acqPhase), .convClkEn(convClkEn), .result_ready_flag(result_ready_flag),
  .conversion_active_pin(conversion_active_pin), .port_zero_line_five(port_zero_line_five),
  .portZeroLineFiveEn(portZeroLineFiveEn));
